// >>> design/flash_access_pkg.sv
// constants shared by both ends of the sectored flash access block.
// assumes a 16-bit byte address space with the flash at its top.
package flash_access_pkg;

  // entry sequence and frame layout of the serial link
  localparam int ENTRY_PULSES = 36;
  localparam int CMD_BITS = 32;
  localparam int RESP_START = 32;
  localparam int FRAME_EDGES = 41;

  // sector layout
  localparam int SECTOR_BYTES = 4096;
  localparam logic [15:0] SECTOR0_BASE = 16'hf000;
  localparam logic [15:0] SECTOR1_BASE = 16'he000;
  localparam logic [15:0] TOP_ADDR = 16'hffff;
  localparam logic [7:0] ERASED = 8'hff;

  // link commands
  localparam logic [7:0] OP_NOP = 8'h00;
  localparam logic [7:0] OP_PROG = 8'h01;
  localparam logic [7:0] OP_ERASE_SECT = 8'h02;
  localparam logic [7:0] OP_ERASE_ALL = 8'h03;
  localparam logic [7:0] OP_READ = 8'h04;
  localparam logic [7:0] OP_WR_OPTION = 8'h05;
  localparam logic [7:0] OP_RAM_LOAD = 8'h06;
  localparam logic [7:0] OP_RUN_PROG = 8'h07;
  localparam logic [7:0] OP_RUN_TEST = 8'h08;

  // response codes
  localparam logic [7:0] RESP_OK = 8'h00;
  localparam logic [7:0] RESP_REFUSED = 8'hfe;
  localparam logic [7:0] RESP_BUSY = 8'hee;

  // application-side operations
  localparam logic [1:0] IAP_PROG = 2'h0;
  localparam logic [1:0] IAP_ERASE = 2'h1;
  localparam logic [1:0] IAP_READ = 2'h2;

  // guard unlock keys, values arbitrary
  localparam logic [7:0] GUARD_KEY1 = 8'h56;
  localparam logic [7:0] GUARD_KEY2 = 8'hae;

  // sector of an address: 0 top 4K, 1 next 4K, 2 the rest
  function automatic logic [1:0] sector_of(input logic [15:0] addr);
    if (addr >= SECTOR0_BASE) begin
      sector_of = 2'd0;
    end else if (addr >= SECTOR1_BASE) begin
      sector_of = 2'd1;
    end else begin
      sector_of = 2'd2;
    end
  endfunction : sector_of

endpackage : flash_access_pkg

// >>> design/flash_icc_if.sv
// serial link between programming tool and device.
// assumes a pull-up on the data line when nobody drives it.
`timescale 1ns/1ps
interface flash_icc_if;
  logic prog_serial_clock;
  logic io_host_out;
  logic io_host_oe;
  logic io_dev_out;
  logic io_dev_oe;
  logic prog_serial_io;
  logic prog_reset_n;
  logic prog_voltage_select;
  logic tool_present;

  // wire level from the two enables
  assign prog_serial_io = io_host_oe ? io_host_out : (io_dev_oe ? io_dev_out : 1'b1);

  modport host (
    output prog_serial_clock,
    output io_host_out,
    output io_host_oe,
    output prog_reset_n,
    output prog_voltage_select,
    output tool_present,
    input prog_serial_io
  );

  modport device (
    input prog_serial_clock,
    output io_dev_out,
    output io_dev_oe,
    input prog_serial_io,
    input prog_reset_n,
    input prog_voltage_select,
    input tool_present
  );
endinterface : flash_icc_if

// >>> design/flash_sector_protection_access.sv
// device end: sectored flash with protection, mode checks and link slave.
// assumes the link clock runs only during entry and frames and that the
// tool keeps the option-select line low while not attached.
`timescale 1ns/1ps
module flash_sector_protection_access
  import flash_access_pkg::*;
#(
  parameter int FLASH_KB = 16,
  parameter int RAM_BYTES = 256,
  parameter logic PROTECT_INIT = 1'b0
) (
  input wire logic core_clk,
  input wire logic sys_rst,
  flash_icc_if.device link,
  input wire logic iap_req,
  input wire logic [1:0] iap_op,
  input wire logic [15:0] iap_addr,
  input wire logic [7:0] iap_data,
  input wire logic guard_key_valid,
  input wire logic [7:0] guard_key,
  output logic iap_done_q,
  output logic iap_err_q,
  output logic [7:0] iap_rdata_q,
  output logic busy_q,
  output logic readout_protect_bit_q,
  output logic in_circuit_comm_mode_q,
  output logic pins_claimed_q,
  output logic ram_run_prog_q,
  output logic ram_run_test_q
);
  localparam int FLASH_BYTES = FLASH_KB * 1024;
  localparam int AW = $clog2(FLASH_BYTES);
  localparam int RW = $clog2(RAM_BYTES);
  localparam logic [16:0] BASE17 = 17'h10000 - 17'(FLASH_BYTES);
  localparam logic [15:0] FLASH_BASE = BASE17[15:0];
  localparam logic [1:0] NUM_SECT = (FLASH_KB <= 4) ? 2'd1 : ((FLASH_KB <= 8) ? 2'd2 : 2'd3);

  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_ERASE = 2'b10
  } core_state_t;

  ////////////////////////////////////////////////////////////////////
  // link domain, clocked by the tool's serial clock
  logic [5:0] pulse_cnt_q;
  logic rst_high_q;
  logic active_q;
  logic [5:0] edge_q;
  logic [31:0] sh_q;
  logic [31:0] cmd_q;
  logic req_tgl_q;
  logic [7:0] resp_sh_q;
  logic [7:0] resp_hold_q;
  logic io_oe_q;
  logic io_out_q;
  logic [2:0] done_sync_q;
  logic [7:0] resp_q;
  logic done_tgl_q;
  wire resp_ready = (done_sync_q[1] == done_sync_q[2]) && (done_sync_q[2] == req_tgl_q);
  wire [7:0] resp_word = resp_ready ? resp_q : RESP_BUSY;

  // async clear only while the tool has the select line low
  always_ff @(posedge link.prog_serial_clock or negedge link.prog_voltage_select) begin
    if (!link.prog_voltage_select) begin
      pulse_cnt_q <= 6'h00;
      rst_high_q <= 1'b0;
      active_q <= 1'b0;
      edge_q <= 6'h00;
      sh_q <= 32'h0;
      cmd_q <= 32'h0;
      req_tgl_q <= 1'b0;
      resp_sh_q <= 8'h00;
      resp_hold_q <= 8'h00;
      io_oe_q <= 1'b0;
      io_out_q <= 1'b0;
      done_sync_q <= 3'h0;
    end else begin
      done_sync_q <= {done_sync_q[1:0], done_tgl_q};
      if (!link.prog_reset_n) begin
        // count pulses under reset, restart after any release
        pulse_cnt_q <= rst_high_q ? 6'h01 : (&pulse_cnt_q ? pulse_cnt_q : pulse_cnt_q + 6'h01);
        rst_high_q <= 1'b0;
        active_q <= 1'b0;
        edge_q <= 6'h00;
        io_oe_q <= 1'b0;
      end else begin
        rst_high_q <= 1'b1;
        active_q <= (pulse_cnt_q == 6'(ENTRY_PULSES));
        if (active_q) begin
          edge_q <= (edge_q == 6'(FRAME_EDGES - 1)) ? 6'h00 : edge_q + 6'h01;
          if (edge_q < 6'(CMD_BITS)) begin
            sh_q <= {sh_q[30:0], link.prog_serial_io};
          end
          if (edge_q == 6'(CMD_BITS - 1)) begin
            cmd_q <= {sh_q[30:0], link.prog_serial_io};
            // latch the previous result before the new toggle hides it
            resp_hold_q <= resp_word;
            req_tgl_q <= ~req_tgl_q;
          end
          if (edge_q == 6'(RESP_START)) begin
            io_oe_q <= 1'b1;
            io_out_q <= resp_hold_q[7];
            resp_sh_q <= {resp_hold_q[6:0], 1'b0};
          end else if (edge_q == 6'(FRAME_EDGES - 1)) begin
            io_oe_q <= 1'b0;
          end else if (edge_q > 6'(RESP_START)) begin
            io_out_q <= resp_sh_q[7];
            resp_sh_q <= {resp_sh_q[6:0], 1'b0};
          end
        end
      end
    end
  end

  assign link.io_dev_oe = io_oe_q;
  assign link.io_dev_out = io_out_q;

  ////////////////////////////////////////////////////////////////////
  // crossings into the core domain
  logic [2:0] req_sync_q;
  logic [2:0] act_sync_q;
  logic [2:0] tool_sync_q;
  logic req_seen_q;
  wire req_stable = req_sync_q[1] == req_sync_q[2];
  // cmd_q is quiet until the next frame's last command bit
  wire icp_go = req_stable && (req_sync_q[2] != req_seen_q);

  always_ff @(posedge core_clk) begin
    req_sync_q <= {req_sync_q[1:0], req_tgl_q};
    act_sync_q <= {act_sync_q[1:0], active_q};
    tool_sync_q <= {tool_sync_q[1:0], link.tool_present};
  end

  ////////////////////////////////////////////////////////////////////
  // request decode
  logic [7:0] flash [FLASH_BYTES];
  logic [7:0] ram [RAM_BYTES];
  core_state_t state_q;
  logic [AW-1:0] ptr_q;
  logic [AW-1:0] hi_q;
  logic clear_prot_q;
  logic guard_stage_q;
  logic guard_armed_q;
  wire comm_mode = act_sync_q[2] && (act_sync_q[1] == act_sync_q[2]);
  wire idle = state_q == ST_IDLE;
  wire take_icp = icp_go && idle;
  wire take_iap = iap_req && idle && !take_icp;
  wire [7:0] c_op = cmd_q[31:24];
  wire [15:0] c_addr = cmd_q[23:8];
  wire [7:0] c_data = cmd_q[7:0];
  wire [15:0] addr = take_icp ? c_addr : iap_addr;
  wire [1:0] sect = sector_of(addr);
  wire in_flash = addr >= FLASH_BASE;
  wire sect_ok = in_flash && (sect < NUM_SECT);
  wire [AW-1:0] idx = AW'(addr - FLASH_BASE);
  // sectors 0 and 1 are fixed 4K windows at the top
  wire [15:0] s_lo = (sect == 2'd0) ? SECTOR0_BASE : ((sect == 2'd1) ? SECTOR1_BASE : FLASH_BASE);
  wire [15:0] s_hi = (sect == 2'd0) ? TOP_ADDR : ((sect == 2'd1) ? 16'(SECTOR0_BASE - 16'h0001)
                     : 16'(SECTOR1_BASE - 16'h0001));
  wire prot = readout_protect_bit_q;
  // tool mode: everything unless protected
  wire icp_wr_ok = comm_mode && !prot && sect_ok;
  // application mode: guard armed, never sector 0
  wire iap_wr_ok = guard_armed_q && sect_ok && (sect != 2'd0);
  wire icp_prog = take_icp && c_op == OP_PROG && icp_wr_ok;
  wire icp_esec = take_icp && c_op == OP_ERASE_SECT && icp_wr_ok;
  wire icp_eall = take_icp && c_op == OP_ERASE_ALL && comm_mode && !prot;
  wire icp_opt = take_icp && c_op == OP_WR_OPTION && comm_mode;
  wire unprotect = icp_opt && prot && !c_data[0];
  wire icp_rd = take_icp && c_op == OP_READ && comm_mode && !prot && sect_ok;
  wire icp_rload = take_icp && c_op == OP_RAM_LOAD && comm_mode;
  wire iap_prog = take_iap && iap_op == IAP_PROG && iap_wr_ok;
  wire iap_esec = take_iap && iap_op == IAP_ERASE && iap_wr_ok;
  wire iap_rd = take_iap && iap_op == IAP_READ && sect_ok;
  wire start_all = icp_eall || unprotect;
  wire start_sect = icp_esec || iap_esec;
  wire icp_known = c_op == OP_NOP || c_op == OP_RUN_PROG || c_op == OP_RUN_TEST;
  wire icp_good = icp_prog || icp_esec || icp_eall || icp_opt || icp_rd || icp_rload
                  || (comm_mode && icp_known);

  // single write port: program byte or erase step
  wire mem_we = icp_prog || iap_prog || state_q == ST_ERASE;
  wire [AW-1:0] mem_wa = (state_q == ST_ERASE) ? ptr_q : idx;
  wire [7:0] mem_wd = (state_q == ST_ERASE) ? ERASED : (take_icp ? c_data : iap_data);

  always_ff @(posedge core_clk) begin
    if (mem_we) begin
      flash[mem_wa] <= mem_wd;
    end
    if (icp_rload) begin
      ram[RW'(c_addr)] <= c_data;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // core state
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      state_q <= ST_IDLE;
      ptr_q <= '0;
      hi_q <= '0;
      clear_prot_q <= 1'b0;
      readout_protect_bit_q <= PROTECT_INIT;
      guard_stage_q <= 1'b0;
      guard_armed_q <= 1'b0;
      req_seen_q <= 1'b0;
      resp_q <= RESP_OK;
      done_tgl_q <= 1'b0;
      iap_done_q <= 1'b0;
      iap_err_q <= 1'b0;
      iap_rdata_q <= 8'h00;
      busy_q <= 1'b0;
      in_circuit_comm_mode_q <= 1'b0;
      pins_claimed_q <= 1'b0;
      ram_run_prog_q <= 1'b0;
      ram_run_test_q <= 1'b0;
    end else begin
      in_circuit_comm_mode_q <= comm_mode;
      // pins belong to the tool whenever it is plugged
      pins_claimed_q <= tool_sync_q[2] && (tool_sync_q[1] == tool_sync_q[2]);
      if (take_icp) begin
        req_seen_q <= req_sync_q[2];
      end
      // two-key unlock, one request per unlock
      if (guard_key_valid) begin
        guard_stage_q <= guard_key == GUARD_KEY1;
        guard_armed_q <= guard_stage_q && guard_key == GUARD_KEY2;
      end else if (take_iap) begin
        guard_armed_q <= 1'b0;
      end
      iap_done_q <= take_iap;
      if (take_iap) begin
        iap_err_q <= !(iap_prog || iap_esec || iap_rd);
        iap_rdata_q <= iap_rd ? flash[idx] : 8'h00;
      end
      ram_run_prog_q <= take_icp && comm_mode && c_op == OP_RUN_PROG;
      ram_run_test_q <= take_icp && comm_mode && c_op == OP_RUN_TEST;
      if (take_icp) begin
        resp_q <= icp_rd ? flash[idx] : (icp_good ? RESP_OK : RESP_REFUSED);
      end
      if (icp_opt && !unprotect) begin
        readout_protect_bit_q <= c_data[0];
      end
      case (state_q)
        ST_IDLE: begin
          if (start_all) begin
            ptr_q <= '0;
            hi_q <= AW'(FLASH_BYTES - 1);
            clear_prot_q <= unprotect;
            state_q <= ST_ERASE;
            busy_q <= 1'b1;
          end else if (start_sect) begin
            ptr_q <= AW'(s_lo - FLASH_BASE);
            hi_q <= AW'(s_hi - FLASH_BASE);
            clear_prot_q <= 1'b0;
            state_q <= ST_ERASE;
            busy_q <= 1'b1;
          end else if (take_icp) begin
            done_tgl_q <= req_sync_q[2];
          end
        end
        ST_ERASE: begin
          ptr_q <= ptr_q + AW'(1);
          if (ptr_q == hi_q) begin
            state_q <= ST_IDLE;
            busy_q <= 1'b0;
            done_tgl_q <= req_seen_q;
            if (clear_prot_q) begin
              readout_protect_bit_q <= 1'b0;
            end
          end
        end
        default: begin
          state_q <= ST_IDLE;
          busy_q <= 1'b0;
        end
      endcase
    end
  end

endmodule : flash_sector_protection_access

// >>> design/flash_prog_tool.sv
// tool end: drives entry sequence, serial clock, frames and reset.
// assumes the device end sits on the same link interface.
`timescale 1ns/1ps
module flash_prog_tool
  import flash_access_pkg::*;
#(
  parameter int HALF_DIV = 4,
  parameter int GAP_CYCLES = 16
) (
  input wire logic core_clk,
  input wire logic sys_rst,
  flash_icc_if.host link,
  input wire logic enter_req,
  input wire logic leave_req,
  input wire logic frame_req,
  input wire logic [7:0] frame_op,
  input wire logic [15:0] frame_addr,
  input wire logic [7:0] frame_data,
  output logic ready_q,
  output logic in_session_q,
  output logic [7:0] resp_q,
  output logic resp_valid_q
);
  typedef enum logic [5:0] {
    H_IDLE = 6'b000001,
    H_ENTRY = 6'b000010,
    H_WAKE = 6'b000100,
    H_SESSION = 6'b001000,
    H_FRAME = 6'b010000,
    H_GAP = 6'b100000
  } tool_state_t;

  tool_state_t state_q;
  logic [7:0] div_q;
  logic [7:0] gap_q;
  logic [5:0] cnt_q;
  logic [31:0] sh_q;
  logic [7:0] rsh_q;
  logic scl_q;
  logic rst_n_q;
  logic vpp_q;
  logic tool_q;
  logic io_out_q;
  logic io_oe_q;
  logic [2:0] io_sync_q;

  ////////////////////////////////////////////////////////////////////
  // link clock from a divider, only while pulsing
  wire run = state_q == H_ENTRY || state_q == H_WAKE || state_q == H_FRAME;
  wire tick = run && div_q == 8'(HALF_DIV - 1);
  wire rise = tick && !scl_q;
  wire fall = tick && scl_q;

  always_ff @(posedge core_clk) begin
    io_sync_q <= {io_sync_q[1:0], link.prog_serial_io};
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      state_q <= H_IDLE;
      div_q <= 8'h00;
      gap_q <= 8'h00;
      cnt_q <= 6'h00;
      sh_q <= 32'h0;
      rsh_q <= 8'h00;
      scl_q <= 1'b0;
      rst_n_q <= 1'b1;
      vpp_q <= 1'b0;
      tool_q <= 1'b0;
      io_out_q <= 1'b0;
      io_oe_q <= 1'b0;
      ready_q <= 1'b0;
      in_session_q <= 1'b0;
      resp_q <= 8'h00;
      resp_valid_q <= 1'b0;
    end else begin
      tool_q <= 1'b1;
      resp_valid_q <= 1'b0;
      div_q <= (!run || tick) ? 8'h00 : div_q + 8'h01;
      if (rise) begin
        scl_q <= 1'b1;
      end else if (fall) begin
        scl_q <= 1'b0;
      end
      case (state_q)
        H_IDLE: begin
          if (enter_req) begin
            // reset held for the whole count
            vpp_q <= 1'b1;
            rst_n_q <= 1'b0;
            cnt_q <= 6'h00;
            state_q <= H_ENTRY;
          end
        end
        H_ENTRY: begin
          if (fall) begin
            cnt_q <= cnt_q + 6'h01;
            if (cnt_q == 6'(ENTRY_PULSES - 1)) begin
              rst_n_q <= 1'b1;
              state_q <= H_WAKE;
            end
          end
        end
        H_WAKE: begin
          // one pulse with reset released lets the device latch the mode
          if (fall) begin
            state_q <= H_SESSION;
            in_session_q <= 1'b1;
            ready_q <= 1'b1;
          end
        end
        H_SESSION: begin
          if (leave_req) begin
            vpp_q <= 1'b0;
            in_session_q <= 1'b0;
            ready_q <= 1'b0;
            state_q <= H_IDLE;
          end else if (frame_req) begin
            sh_q <= {frame_op, frame_addr, frame_data};
            io_out_q <= frame_op[7];
            io_oe_q <= 1'b1;
            cnt_q <= 6'h00;
            ready_q <= 1'b0;
            state_q <= H_FRAME;
          end
        end
        H_FRAME: begin
          if (rise && cnt_q > 6'(RESP_START)) begin
            rsh_q <= {rsh_q[6:0], io_sync_q[2]};
          end
          if (fall) begin
            cnt_q <= cnt_q + 6'h01;
            if (cnt_q < 6'(CMD_BITS - 1)) begin
              io_out_q <= sh_q[30];
              sh_q <= {sh_q[30:0], 1'b0};
            end else if (cnt_q == 6'(CMD_BITS - 1)) begin
              // release before the device starts answering
              io_oe_q <= 1'b0;
            end
            if (cnt_q == 6'(FRAME_EDGES - 1)) begin
              resp_q <= rsh_q;
              resp_valid_q <= 1'b1;
              gap_q <= 8'h00;
              state_q <= H_GAP;
            end
          end
        end
        H_GAP: begin
          gap_q <= gap_q + 8'h01;
          if (gap_q == 8'(GAP_CYCLES - 1)) begin
            ready_q <= 1'b1;
            state_q <= H_SESSION;
          end
        end
        default: begin
          state_q <= H_IDLE;
        end
      endcase
    end
  end

  assign link.prog_serial_clock = scl_q;
  assign link.prog_reset_n = rst_n_q;
  assign link.prog_voltage_select = vpp_q;
  assign link.tool_present = tool_q;
  assign link.io_host_out = io_out_q;
  assign link.io_host_oe = io_oe_q;

endmodule : flash_prog_tool

// >>> sim/flash_link_checker.sv
// link checker: watches the serial link between tool and device.
// assumes a tool divider of 4 core cycles a half period.
`timescale 1ns/1ps
module flash_link_checker
  import flash_access_pkg::*;
(
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic prog_serial_clock,
  input wire logic io_host_out,
  input wire logic io_host_oe,
  input wire logic io_dev_out,
  input wire logic io_dev_oe,
  input wire logic prog_serial_io,
  input wire logic prog_reset_n,
  input wire logic prog_voltage_select,
  input wire logic tool_present
);
  logic seen_q;
  logic [7:0] pulses_q;
  logic [7:0] pulses_d;
  // count link clock rises while the device is held in reset
  assign pulses_d = prog_reset_n ? 8'h00 : pulses_q + {7'h00, prog_serial_clock & ~seen_q};
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      seen_q <= 1'b0;
      pulses_q <= 8'h00;
    end else begin
      seen_q <= prog_serial_clock;
      pulses_q <= pulses_d;
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  default clocking @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  no_contention_a: assert property (!(io_host_oe && io_dev_oe))
    else $error("both ends drive the data line");
  dev_in_session_a: assert property (io_dev_oe |-> prog_voltage_select)
    else $error("device drives data outside a session");
  select_present_a: assert property (prog_voltage_select |-> tool_present)
    else $error("select raised without tool present");
  reset_in_entry_a: assert property ($fell(prog_reset_n) |-> prog_voltage_select)
    else $error("device reset dropped outside entry");
  entry_count_a: assert property ($rose(prog_reset_n) |-> pulses_q == 8'(ENTRY_PULSES))
    else $error("wrong entry pulse count");
  clock_high_a: assert property ($rose(prog_serial_clock) |->
    prog_serial_clock[*4] ##1 !prog_serial_clock)
    else $error("link clock high phase wrong");
  frame_reset_a: assert property ($rose(io_host_oe) |-> prog_reset_n && prog_voltage_select)
    else $error("frame started with device in reset");
  host_stable_a: assert property (io_host_oe && prog_serial_clock && $past(prog_serial_clock)
    |-> $stable(io_host_out))
    else $error("tool data changed while clock high");
  handover_a: assert property ($fell(io_host_oe) |-> ##[1:12] io_dev_oe)
    else $error("device did not take the data line");
endmodule : flash_link_checker

// >>> sim/flash_sector_protection_access_tb.sv
// bench: tool and device joined by the link; drives both user sides.
// assumes the package opcodes and response codes of the design.
`timescale 1ns/1ps
module flash_sector_protection_access_tb;
  import flash_access_pkg::*;
  logic core_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic enter_req = 1'b0, leave_req = 1'b0, frame_req = 1'b0;
  logic [7:0] frame_op = 8'h00, frame_data = 8'h00;
  logic [15:0] frame_addr = 16'h0000;
  logic ready_q, in_session_q, resp_valid_q;
  logic [7:0] resp_q;
  logic iap_req = 1'b0, guard_key_valid = 1'b0;
  logic [1:0] iap_op = 2'h0;
  logic [15:0] iap_addr = 16'h0000;
  logic [7:0] iap_data = 8'h00, guard_key = 8'h00;
  logic iap_done_q, iap_err_q, busy_q, readout_protect_bit_q, in_circuit_comm_mode_q;
  logic pins_claimed_q, ram_run_prog_q, ram_run_test_q;
  logic [7:0] iap_rdata_q;
  logic [8:0] link_q[$];
  logic [9:0] iap_q[$];
  logic [8:0] pend = 9'h100;
  logic [7:0] d0, d1;
  logic [1:0] runs = 2'b00;
  integer seed = 32'ha6c888e7;
  int n_mismatch = 0;
  int tests_run = 0;
  always #25 core_clk = ~core_clk;
  flash_icc_if link ();
  flash_prog_tool #(.HALF_DIV(4), .GAP_CYCLES(16)) flash_prog_tool_i (.core_clk(core_clk),
    .sys_rst(sys_rst), .link(link), .enter_req(enter_req), .leave_req(leave_req),
    .frame_req(frame_req), .frame_op(frame_op), .frame_addr(frame_addr),
    .frame_data(frame_data), .ready_q(ready_q), .in_session_q(in_session_q),
    .resp_q(resp_q), .resp_valid_q(resp_valid_q));
  // 8K array: sectors 0 and 1 only, so 0xd000 lies below the flash
  flash_sector_protection_access #(.FLASH_KB(8)) flash_sector_protection_access_i (
    .core_clk(core_clk), .sys_rst(sys_rst), .link(link), .iap_req(iap_req),
    .iap_op(iap_op), .iap_addr(iap_addr), .iap_data(iap_data),
    .guard_key_valid(guard_key_valid), .guard_key(guard_key), .iap_done_q(iap_done_q),
    .iap_err_q(iap_err_q), .iap_rdata_q(iap_rdata_q), .busy_q(busy_q),
    .readout_protect_bit_q(readout_protect_bit_q),
    .in_circuit_comm_mode_q(in_circuit_comm_mode_q), .pins_claimed_q(pins_claimed_q),
    .ram_run_prog_q(ram_run_prog_q), .ram_run_test_q(ram_run_test_q));
  flash_link_checker flash_link_checker_i (.core_clk(core_clk), .sys_rst(sys_rst),
    .prog_serial_clock(link.prog_serial_clock), .io_host_out(link.io_host_out),
    .io_host_oe(link.io_host_oe), .io_dev_out(link.io_dev_out), .io_dev_oe(link.io_dev_oe),
    .prog_serial_io(link.prog_serial_io), .prog_reset_n(link.prog_reset_n),
    .prog_voltage_select(link.prog_voltage_select), .tool_present(link.tool_present));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [8:0] e, input logic [8:0] g);
    tests_run++;
    if (g !== e) begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic end_of_test();
    if (n_mismatch == 0 && tests_run > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : end_of_test
  // response of a frame belongs to the frame before it
  always @(posedge core_clk) begin
    if (ram_run_prog_q === 1'b1) runs[0] = 1'b1;
    if (ram_run_test_q === 1'b1) runs[1] = 1'b1;
    if (resp_valid_q === 1'b1) begin
      if (link_q.size() == 0) begin
        chk("link_q", 9'h0, 9'h1ff);
      end else if (!link_q[0][8]) begin
        chk("resp_q", link_q[0], {1'b0, resp_q});
      end
      if (link_q.size() != 0) begin
        void'(link_q.pop_front());
      end
    end
    if (iap_done_q === 1'b1 && iap_q.size() != 0) begin
      chk("iap_err_q", {8'h0, iap_q[0][8]}, {8'h0, iap_err_q});
      if (iap_q[0][9]) begin
        chk("iap_rdata_q", {1'b0, iap_q[0][7:0]}, {1'b0, iap_rdata_q});
      end
      void'(iap_q.pop_front());
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  task automatic xfer(input logic [7:0] op, input logic [15:0] a, input logic [7:0] d,
                      input logic [8:0] e);
    int i;
    for (i = 0; i < 400 && ready_q !== 1'b1; i++) @(negedge core_clk);
    link_q.push_back(pend);
    pend = e;
    frame_op = op;
    frame_addr = a;
    frame_data = d;
    frame_req = 1'b1;
    @(negedge core_clk);
    frame_req = 1'b0;
    for (i = 0; i < 600 && resp_valid_q !== 1'b1; i++) @(negedge core_clk);
  endtask : xfer
  // erase runs long; let busy clear before the next request
  task automatic settle();
    int i;
    repeat (4) @(negedge core_clk);
    for (i = 0; i < 20000 && busy_q !== 1'b0; i++) @(negedge core_clk);
  endtask : settle
  task automatic in_application_programming_mode(input logic arm, input logic [1:0] op, input logic [15:0] a,
                     input logic [9:0] e);
    if (arm) begin
      guard_key_valid = 1'b1;
      guard_key = GUARD_KEY1;
      @(negedge core_clk);
      guard_key = GUARD_KEY2;
      @(negedge core_clk);
      guard_key_valid = 1'b0;
    end
    iap_q.push_back(e);
    {iap_op, iap_addr, iap_data, iap_req} = {op, a, d0, 1'b1};
    @(negedge core_clk);
    iap_req = 1'b0;
    settle();
  endtask : in_application_programming_mode
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (6) @(negedge core_clk);
    sys_rst = 1'b0;
    chk("readout_protect_bit_q", 9'h0, {8'h0, readout_protect_bit_q});
    repeat (6) @(negedge core_clk);
    d0 = 8'($random(seed));
    d1 = 8'($random(seed));
    enter_req = 1'b1;
    @(negedge core_clk);
    enter_req = 1'b0;
    for (int i = 0; i < 2000 && ready_q !== 1'b1; i++) @(negedge core_clk);
    chk("pins_claimed_q", 9'h1, {8'h0, pins_claimed_q});
    chk("in_circuit_comm_mode_q", 9'h1, {8'h0, in_circuit_comm_mode_q});
    xfer(OP_ERASE_ALL, 16'h0000, 8'h00, RESP_OK);
    settle();
    xfer(OP_PROG, SECTOR0_BASE, d0, RESP_OK);
    xfer(OP_PROG, 16'he010, d1, RESP_OK);
    xfer(OP_READ, TOP_ADDR, 8'h00, ERASED);
    xfer(OP_READ, SECTOR0_BASE, 8'h00, {1'b0, d0});
    xfer(OP_ERASE_SECT, SECTOR1_BASE, 8'h00, RESP_OK);
    settle();
    xfer(OP_READ, 16'he010, 8'h00, ERASED);
    xfer(OP_READ, SECTOR0_BASE, 8'h00, {1'b0, d0});
    xfer(OP_PROG, 16'hd000, d1, RESP_REFUSED);
    xfer(OP_ERASE_SECT, 16'hd000, 8'h00, RESP_REFUSED);
    for (int k = 6; k <= 8; k++) xfer(8'(k), 16'h0000, d1, RESP_OK);
    xfer(OP_WR_OPTION, 16'h0000, 8'h01, RESP_OK);
    xfer(OP_READ, SECTOR0_BASE, 8'h00, RESP_REFUSED);
    xfer(OP_PROG, 16'he001, d1, RESP_REFUSED);
    chk("readout_protect_bit_q", 9'h1, {8'h0, readout_protect_bit_q});
    xfer(OP_WR_OPTION, 16'h0000, 8'h00, RESP_OK);
    settle();
    xfer(OP_READ, SECTOR0_BASE, 8'h00, ERASED);
    xfer(OP_PROG, 16'he030, d1, RESP_OK);
    xfer(OP_ERASE_ALL, 16'h0000, 8'h00, RESP_OK);
    settle();
    xfer(OP_READ, 16'he030, 8'h00, ERASED);
    xfer(OP_NOP, 16'h0000, 8'h00, RESP_OK);
    chk("readout_protect_bit_q", 9'h0, {8'h0, readout_protect_bit_q});
    chk("ram_run", 9'h3, {7'h0, runs});
    leave_req = 1'b1;
    @(negedge core_clk);
    leave_req = 1'b0;
    for (int i = 0; i < 600 && in_session_q !== 1'b0; i++) @(negedge core_clk);
    in_application_programming_mode(1'b1, IAP_PROG, 16'he020, 10'h000);
    in_application_programming_mode(1'b0, IAP_PROG, 16'he021, 10'h100);
    in_application_programming_mode(1'b1, IAP_PROG, 16'hf001, 10'h100);
    in_application_programming_mode(1'b1, IAP_ERASE, SECTOR0_BASE, 10'h100);
    in_application_programming_mode(1'b1, IAP_READ, 16'he020, {2'b10, d0});
    in_application_programming_mode(1'b1, IAP_ERASE, SECTOR1_BASE, 10'h000);
    in_application_programming_mode(1'b1, IAP_READ, 16'he020, {2'b10, ERASED});
    end_of_test();
  end
  // whole sequence needs well under 60k cycles
  initial begin
    #(100000 * 50);
    n_mismatch++;
    end_of_test();
  end
endmodule : flash_sector_protection_access_tb
